// ---- include/wrmc_pkg.sv ----
// constants and types shared by the waveform run-mode control block
package wrmc_pkg;
    // ------------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int SAMPLE_W   = 16;
    localparam int MEM_DEPTH  = 64;
    localparam int PTR_W      = 6;
    localparam int FIFO_DEPTH = 16;
    localparam int PEND_W     = 4;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FORCE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LAST   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_WADDR  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_WDATA  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_OEN_BIT  = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_POL_BIT  = 4;
    localparam int FORCE_BIT     = 0;
    localparam int ST_PLAY_BIT   = 2;
    localparam int ST_PEND_LSB   = 4;
    localparam logic [PTR_W-1:0]  LAST_RST = 6'h3f;
    localparam logic [PEND_W-1:0] PEND_MAX = 4'hf;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CONT  = 2'b00,
        MODE_TRIG  = 2'b01,
        MODE_GATED = 2'b10
    } wrmc_mode_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_PLAY = 1'b1
    } wrmc_state_e;
endpackage : wrmc_pkg

// ---- include/wrmc_fifo_if.sv ----
// sample stream between the sequencer and the fifo
`timescale 1ns/1ps
interface wrmc_fifo_if;
    import wrmc_pkg::*;
    logic                flush;
    logic                push_valid;
    logic                push_ready;
    logic [SAMPLE_W-1:0] push_data;
    logic                pop_valid;
    logic                pop_ready;
    logic [SAMPLE_W-1:0] pop_data;
    logic [4:0]          level;

    modport user (output flush, push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data, level);
    modport fifo (input  flush, push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, level);
endinterface : wrmc_fifo_if

// ---- hw/wrmc_edge.sv ----
// registered level with rising and falling edge pulses
`timescale 1ns/1ps
module wrmc_edge #(
    parameter logic RST_LVL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_lvl,
    output logic      o_lvl,
    output logic      o_rise,
    output logic      o_fall
);
    logic lvl_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_r <= RST_LVL;
        end else begin
            lvl_r <= i_lvl;
        end
    end

    assign o_lvl  = lvl_r;
    assign o_rise = i_lvl & ~lvl_r;
    assign o_fall = ~i_lvl & lvl_r;
endmodule : wrmc_edge

// ---- hw/wrmc_fifo.sv ----
// sample fifo with flush, valid/ready on both sides
`timescale 1ns/1ps
module wrmc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    wrmc_fifo_if.fifo   f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              do_push = f.push_valid & f.push_ready;
    wire              do_pop  = f.pop_valid & f.pop_ready;

    // full compare must keep the count's top bit, or an empty fifo reads as full
    assign f.push_ready = (cnt_r != (AW+1)'(DEPTH)) & ~f.flush;
    assign f.pop_valid  = (cnt_r != '0) & ~f.flush;
    assign f.pop_data   = mem[rp_r];
    assign f.level      = 5'(cnt_r);

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wp_r] <= f.push_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (f.flush) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= do_push ? AW'(wp_r + 1'b1) : wp_r;
            rp_r  <= do_pop ? AW'(rp_r + 1'b1) : rp_r;
            cnt_r <= (AW+1)'(cnt_r + do_push - do_pop);
        end
    end
endmodule : wrmc_fifo

// ---- hw/wrmc_top.sv ----
// run-mode control: waveform store, sequencer, fifo and output stage
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - continuous mode replays the stored waveform endlessly once run and output are on.
// - triggered mode plays one whole waveform cycle per force-trigger press.
// - triggered mode plays one whole waveform cycle per qualifying external trigger edge.
// - gated mode plays continuously while force-trigger is held.
// - gated mode stops output once force-trigger is released and the external gate is closed.
// - gated, positive polarity: output only while external gate is high or force-trigger is held.
// - polarity setting; negative inverts the sense of the trigger/gate input.
// - gated, negative polarity: output only while external gate is low or force-trigger is held.
module wrmc_top
    import wrmc_pkg::*;
(
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_RESET_N,
    input  wire logic [ADDR_W-1:0]   I_ADDR,
    input  wire logic [DATA_W-1:0]   I_WDATA,
    input  wire logic                I_WR,
    input  wire logic                I_RD,
    output logic      [DATA_W-1:0]   O_RDATA,
    input  wire logic                I_EXTERNAL_TRIGGER_INPUT,
    input  wire logic                I_DAC_READY,
    output logic      [SAMPLE_W-1:0] O_MAIN_ANALOG_OUTPUT,
    output logic                     O_DAC_VALID,
    output logic                     O_RUN_LED,
    output logic                     O_OUT_LED
);
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic                run_r;
    logic                oen_r;
    wrmc_mode_e          mode_r;
    logic                pol_r;
    logic                force_r;
    logic [PTR_W-1:0]    last_r;
    logic [PTR_W-1:0]    waddr_r;
    logic [SAMPLE_W-1:0] wave [MEM_DEPTH];
    logic [DATA_W-1:0]   rdata_r;

    wire wr_ctrl  = I_WR & (I_ADDR == OFS_CTRL);
    wire wr_force = I_WR & (I_ADDR == OFS_FORCE);
    wire wr_last  = I_WR & (I_ADDR == OFS_LAST);
    wire wr_waddr = I_WR & (I_ADDR == OFS_WADDR);
    wire wr_wdata = I_WR & (I_ADDR == OFS_WDATA);

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            run_r   <= 1'b0;
            oen_r   <= 1'b0;
            mode_r  <= MODE_CONT;
            pol_r   <= 1'b0;
            force_r <= 1'b0;
            last_r  <= LAST_RST;
            waddr_r <= '0;
        end else begin
            if (wr_ctrl) begin
                run_r  <= I_WDATA[CTRL_RUN_BIT];
                oen_r  <= I_WDATA[CTRL_OEN_BIT];
                mode_r <= wrmc_mode_e'(I_WDATA[CTRL_MODE_LSB +: 2]);
                pol_r  <= I_WDATA[CTRL_POL_BIT];
            end
            if (wr_force) begin
                force_r <= I_WDATA[FORCE_BIT];
            end
            if (wr_last) begin
                last_r <= I_WDATA[PTR_W-1:0];
            end
            if (wr_waddr) begin
                waddr_r <= I_WDATA[PTR_W-1:0];
            end else if (wr_wdata) begin
                waddr_r <= PTR_W'(waddr_r + 1'b1);
            end
        end
    end

    // loading while playing is allowed; the replay simply picks up new words
    always_ff @(posedge I_SYS_CLK) begin
        if (wr_wdata) begin
            wave[waddr_r] <= I_WDATA[SAMPLE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // trigger and gate qualification
    // ------------------------------------------------------------------
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic frc_rise;

    wrmc_edge #(.RST_LVL(1'b0)) u_ext_edge (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RESET_N),
        .i_lvl   (I_EXTERNAL_TRIGGER_INPUT),
        .o_lvl   (ext_lvl),
        .o_rise  (ext_rise),
        .o_fall  (ext_fall)
    );

    wrmc_edge #(.RST_LVL(1'b0)) u_frc_edge (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RESET_N),
        .i_lvl   (force_r),
        .o_lvl   (),
        .o_rise  (frc_rise),
        .o_fall  ()
    );

    wire enabled   = run_r & oen_r;
    wire is_cont   = (mode_r == MODE_CONT);
    wire is_trig   = (mode_r == MODE_TRIG);
    wire is_gated  = (mode_r == MODE_GATED);
    wire ext_qual  = pol_r ? ext_fall : ext_rise;
    wire ext_gate  = ext_lvl ^ pol_r;
    wire gate_act  = force_r | ext_gate;
    wire drain_ok  = enabled & (~is_gated | gate_act);
    wire flush     = ~drain_ok;

    // ------------------------------------------------------------------
    // pending trigger count
    // ------------------------------------------------------------------
    // a trigger landing in the cycle that ends a replay still counts
    logic [PEND_W-1:0] pend_r;
    logic [PEND_W-1:0] pend_nxt;
    wrmc_state_e       state_r;
    wrmc_state_e       state_nxt;
    logic [PTR_W-1:0]  rd_ptr_r;
    logic [PTR_W-1:0]  rd_ptr_nxt;

    wrmc_fifo_if ff ();

    wire         push     = ff.push_valid & ff.push_ready;
    wire         cyc_end  = push & (rd_ptr_r == last_r);
    wire [1:0]   trig_inc = 2'(is_trig & frc_rise) + 2'(is_trig & ext_qual);
    wire         trig_dec = is_trig & cyc_end;
    wire [PEND_W+1:0] pend_sum = (PEND_W+2)'(pend_r) + (PEND_W+2)'(trig_inc)
                               - (PEND_W+2)'(trig_dec);

    assign pend_nxt = ~enabled ? '0 :
                      (pend_sum > (PEND_W+2)'(PEND_MAX)) ? PEND_MAX :
                      pend_sum[PEND_W-1:0];

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    wire play_go = enabled & (is_cont | (is_gated & gate_act)
                              | (is_trig & (pend_r != '0)));

    always_comb begin
        state_nxt  = state_r;
        rd_ptr_nxt = rd_ptr_r;
        case (state_r)
            ST_IDLE: begin
                rd_ptr_nxt = '0;
                if (play_go) begin
                    state_nxt = ST_PLAY;
                end
            end
            ST_PLAY: begin
                if (cyc_end) begin
                    rd_ptr_nxt = '0;
                    if (is_trig & (pend_nxt == '0)) begin
                        state_nxt = ST_IDLE;
                    end
                end else if (push) begin
                    rd_ptr_nxt = PTR_W'(rd_ptr_r + 1'b1);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (flush) begin
            state_nxt  = ST_IDLE;
            rd_ptr_nxt = '0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r  <= ST_IDLE;
            rd_ptr_r <= '0;
            pend_r   <= '0;
        end else begin
            state_r  <= state_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            pend_r   <= pend_nxt;
        end
    end

    // ------------------------------------------------------------------
    // fifo and output stage
    // ------------------------------------------------------------------
    // the fifo stalls the sequencer when the converter holds ready low
    logic                out_vld_r;
    logic [SAMPLE_W-1:0] out_dat_r;

    assign ff.flush      = flush;
    assign ff.push_valid = (state_r == ST_PLAY);
    assign ff.push_data  = wave[rd_ptr_r];
    assign ff.pop_ready  = drain_ok & (~out_vld_r | I_DAC_READY);

    wrmc_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RESET_N),
        .f       (ff.fifo)
    );

    wire pop = ff.pop_valid & ff.pop_ready;

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            out_vld_r <= 1'b0;
            out_dat_r <= '0;
        end else if (flush) begin
            out_vld_r <= 1'b0;
        end else if (pop) begin
            out_vld_r <= 1'b1;
            out_dat_r <= ff.pop_data;
        end else if (I_DAC_READY) begin
            out_vld_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read port and indicators
    // ------------------------------------------------------------------
    wire [DATA_W-1:0] ctrl_rd  = DATA_W'({pol_r, mode_r, oen_r, run_r});
    wire [DATA_W-1:0] stat_rd  = DATA_W'({ff.level, pend_r, 1'b0,
                                          state_r == ST_PLAY, oen_r, run_r});
    wire [DATA_W-1:0] rd_mux   =
        (I_ADDR == OFS_CTRL)   ? ctrl_rd :
        (I_ADDR == OFS_FORCE)  ? DATA_W'(force_r) :
        (I_ADDR == OFS_LAST)   ? DATA_W'(last_r) :
        (I_ADDR == OFS_WADDR)  ? DATA_W'(waddr_r) :
        (I_ADDR == OFS_STATUS) ? stat_rd : '0;

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_r   <= '0;
            O_RUN_LED <= 1'b0;
            O_OUT_LED <= 1'b0;
        end else begin
            rdata_r   <= I_RD ? rd_mux : '0;
            O_RUN_LED <= run_r;
            O_OUT_LED <= oen_r;
        end
    end

    assign O_RDATA              = rdata_r;
    assign O_DAC_VALID          = out_vld_r;
    assign O_MAIN_ANALOG_OUTPUT = out_dat_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence s_last_push;
        (state_r == ST_PLAY) && cyc_end;
    endsequence

    sequence s_no_more_trig;
        is_trig && (pend_r == 4'h1) && (trig_inc == 2'b00) && enabled;
    endsequence

    a_out_needs_enable: assert property (!enabled |=> !O_DAC_VALID)
        else $error("output valid while run or output enable is off");
    a_led_follow_run: assert property (run_r != O_RUN_LED |=> run_r == O_RUN_LED
                                       || $changed(run_r))
        else $error("run indicator lags the run control");
    a_cont_starts_play: assert property (enabled && is_cont && state_r == ST_IDLE
                                         |=> state_r == ST_PLAY)
        else $error("continuous mode did not start replay");
    a_cont_keeps_play: assert property (s_last_push ##0 (enabled && is_cont)
                                        |=> state_r == ST_PLAY && rd_ptr_r == 6'h00)
        else $error("continuous mode did not wrap to the first sample");
    a_force_counts: assert property (enabled && is_trig && frc_rise && pend_r < 4'hd
                                     |=> pend_r != 4'h0)
        else $error("force trigger was not counted");
    a_ext_edge_counts: assert property (enabled && is_trig && ext_qual && pend_r < 4'hd
                                        |=> pend_r != 4'h0)
        else $error("external trigger edge was not counted");
    a_trig_one_cycle: assert property (s_no_more_trig ##0 s_last_push
                                       |=> state_r == ST_IDLE ##1 !ff.push_valid)
        else $error("triggered replay ran past one waveform cycle");
    a_gate_force_hold: assert property (enabled && is_gated && force_r
                                        |-> drain_ok ##1 state_r == ST_PLAY)
        else $error("held force trigger did not keep gated replay");
    a_gate_release: assert property (enabled && is_gated && $fell(force_r) && !ext_gate
                                     |=> !O_DAC_VALID)
        else $error("gated output kept running after force release");
    a_gate_pos_low: assert property (enabled && is_gated && !pol_r && !ext_lvl && !force_r
                                     |=> !O_DAC_VALID)
        else $error("positive gate low but output continued");
    a_pol_inverts: assert property (is_trig && pol_r && ext_rise |-> !ext_qual)
        else $error("negative polarity accepted a rising edge");
    a_gate_neg_high: assert property (enabled && is_gated && pol_r && ext_lvl && !force_r
                                      |=> !O_DAC_VALID)
        else $error("negative gate high but output continued");
endmodule : wrmc_top

// ---- dv/wrmc_trig_src.sv ----
// behavioural external trigger and gate source for the run-mode control block
`timescale 1ns/1ps
module wrmc_trig_src (
    input  wire logic i_clk,
    output logic      o_level
);
    // ------------------------------------------------------------------
    // level driver
    // ------------------------------------------------------------------
    initial begin
        o_level = 1'b0;
    end

    // changes only just after a rising edge, like a source synchronous to the clock
    task automatic set_level(input logic v);
        @(posedge i_clk);
        o_level <= v;
    endtask : set_level

    // one high pulse of n cycles; back-to-back calls leave one low cycle between pulses
    task automatic pulse(input int n);
        set_level(1'b1);
        repeat (n) @(posedge i_clk);
        o_level <= 1'b0;
    endtask : pulse
endmodule : wrmc_trig_src

// ---- dv/wrmc_top_test.sv ----
// self-checking testbench for the run-mode control block
`timescale 1ns/1ps
module wrmc_top_test;
    import wrmc_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int NSAMP = 5;
    logic                clk;
    logic                rst_n;
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                ext_lvl;
    logic                dac_ready;
    logic [SAMPLE_W-1:0] sample;
    logic                dac_valid;
    logic                run_led;
    logic                out_led;
    int                  mismatches;
    int                  checks;

    always #5 clk = ~clk;

    wrmc_top u_dut (
        .I_SYS_CLK                (clk),
        .I_RESET_N                (rst_n),
        .I_ADDR                   (addr),
        .I_WDATA                  (wdata),
        .I_WR                     (wr),
        .I_RD                     (rd),
        .O_RDATA                  (rdata),
        .I_EXTERNAL_TRIGGER_INPUT (ext_lvl),
        .I_DAC_READY              (dac_ready),
        .O_MAIN_ANALOG_OUTPUT     (sample),
        .O_DAC_VALID              (dac_valid),
        .O_RUN_LED                (run_led),
        .O_OUT_LED                (out_led)
    );

    wrmc_trig_src u_src (
        .i_clk   (clk),
        .o_level (ext_lvl)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [SAMPLE_W-1:0] exp_samp(input int i);
        return 16'h8000 | 16'(i * 16'h0305);
    endfunction : exp_samp

    task automatic print_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : rd_chk

    // takes n samples with the converter stalling every third cycle;
    // each burst restarts at sample 0, so sample k of the run is k mod NSAMP
    task automatic collect(input int n);
        int got;
        int t;
        got = 0;
        t   = 0;
        while (got < n) begin
            @(posedge clk);
            dac_ready <= (t % 3 != 2);
            t++;
            @(negedge clk);
            if (dac_valid === 1'b1 && dac_ready === 1'b1) begin
                chk({16'h0, sample}, {16'h0, exp_samp(got % NSAMP)});
                got++;
            end
            if (t > 40 * n + 40) begin
                chk(32'(got), 32'(n));
                print_verdict();
            end
        end
        @(posedge clk);
        dac_ready <= 1'b0;
    endtask : collect

    // converter ready throughout; no sample may be offered
    task automatic quiet(input int n);
        int seen;
        seen = 0;
        @(posedge clk);
        dac_ready <= 1'b1;
        repeat (n) begin
            @(negedge clk);
            if (dac_valid !== 1'b0) seen++;
        end
        chk(32'(seen), 32'h0);
        @(posedge clk);
        dac_ready <= 1'b0;
    endtask : quiet

    // stop first so the fifo is flushed before the new mode starts
    task automatic setup(input logic [DATA_W-1:0] ctrl);
        wr_reg(OFS_CTRL, 32'h0);
        wr_reg(OFS_CTRL, ctrl);
    endtask : setup

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        wr         = 1'b0;
        rd         = 1'b0;
        dac_ready  = 1'b0;
        mismatches = 0;
        checks     = 0;
        repeat (20) @(posedge clk);
        chk({28'h0, dac_valid, run_led, out_led, |rdata}, 32'h0);
        rst_n <= 1'b1;
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_LAST, 32'h3f);
        rd_chk(OFS_FORCE, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        // waveform load; write data port reads back zero, unmapped space too
        wr_reg(OFS_LAST, 32'(NSAMP - 1));
        wr_reg(OFS_WADDR, 32'h0);
        for (int i = 0; i < NSAMP; i++) wr_reg(OFS_WDATA, {16'h0, exp_samp(i)});
        rd_chk(OFS_WDATA, 32'h0);
        rd_chk(8'h40, 32'h0);
        rd_chk(OFS_LAST, 32'(NSAMP - 1));
        // run alone, then output enable alone: indicators follow, nothing plays
        wr_reg(OFS_CTRL, 32'h01);
        repeat (2) @(negedge clk);
        chk({30'h0, run_led, out_led}, 32'h2);
        rd_chk(OFS_STATUS, 32'h1);
        quiet(20);
        wr_reg(OFS_CTRL, 32'h02);
        repeat (2) @(negedge clk);
        chk({30'h0, run_led, out_led}, 32'h1);
        rd_chk(OFS_STATUS, 32'h2);
        quiet(20);
        // continuous replay wraps without a trigger
        wr_reg(OFS_CTRL, 32'h03);
        collect(3 * NSAMP + 2);
        wr_reg(OFS_CTRL, 32'h01);
        repeat (3) @(posedge clk);
        quiet(10);
        // triggered by force: one press, one waveform cycle
        setup(32'h07);
        quiet(10);
        wr_reg(OFS_FORCE, 32'h1);
        wr_reg(OFS_FORCE, 32'h0);
        collect(NSAMP);
        quiet(30);
        // triggered by two external rising edges, second queued while playing
        u_src.pulse(3);
        u_src.pulse(3);
        collect(2 * NSAMP);
        quiet(30);
        // negative sense in triggered mode: rising edge ignored, falling edge plays
        setup(32'h17);
        u_src.set_level(1'b1);
        quiet(20);
        u_src.set_level(1'b0);
        collect(NSAMP);
        quiet(30);
        // gated by a held force, stops on release
        setup(32'h0b);
        quiet(10);
        wr_reg(OFS_FORCE, 32'h1);
        collect(2 * NSAMP + 1);
        wr_reg(OFS_FORCE, 32'h0);
        repeat (4) @(posedge clk);
        quiet(20);
        // gated by the external level, positive sense
        u_src.set_level(1'b1);
        collect(NSAMP + 2);
        u_src.set_level(1'b0);
        repeat (4) @(posedge clk);
        quiet(20);
        // negative sense: low level opens the gate
        u_src.set_level(1'b1);
        setup(32'h1b);
        quiet(20);
        u_src.set_level(1'b0);
        collect(NSAMP + 3);
        u_src.set_level(1'b1);
        repeat (4) @(posedge clk);
        quiet(20);
        // reset in mid-replay clears the controls, so nothing plays afterwards
        u_src.set_level(1'b0);
        repeat (8) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        chk({29'h0, dac_valid, run_led, out_led}, 32'h0);
        rst_n <= 1'b1;
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_LAST, 32'h3f);
        quiet(10);
        print_verdict();
    end
endmodule : wrmc_top_test
